// file: core/gpcfg_defs.vh
`ifndef GPCFG_DEFS_VH
`define GPCFG_DEFS_VH

// Register byte addresses; printed offsets are all word aligned
`define GPCFG_ADDR_PORT0 8'h80
`define GPCFG_ADDR_PORT1 8'h90
`define GPCFG_ADDR_PORT2 8'ha0
`define GPCFG_ADDR_PORT3 8'hb0
`define GPCFG_ADDR_SETUP 8'hc0

// Reset values
`define GPCFG_LEVELS_RST 8'hff
`define GPCFG_SETUP_RST 8'h00
`define GPCFG_MODE_RST 3'h0

// Field positions in the indirect pin setup register
`define GPCFG_MODE_HI 7
`define GPCFG_MODE_LO 5
`define GPCFG_DIR_BIT 4
`define GPCFG_LATCH_BIT 3
`define GPCFG_IDX_HI 2
`define GPCFG_IDX_LO 0

// Output mode codes
`define GPCFG_OUT_NORMAL 3'h0
`define GPCFG_OUT_HIGH 3'h3

// Package variants
`define GPCFG_PKG_LARGE 2'h2
`define GPCFG_P3_PINS 7

`endif

// file: core/gpcfg_port.v
// Function
// - Clear latch bit writes mode to pin
// - Set latch bit stores pin index pointer
// - Reads return mode of latched pin
// - Indices 0-6 valid, 7 reserved
// - Port level registers, reset all ones
// - Absent package pins act as reserved
// - Direction bit zero output, one input
// - Output modes only normal or high
// - Latch also saves direction, ignores mode
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "gpcfg_defs.vh"


// Register map, all registers live in byte lane 0:
// 0x80 port 0 levels, 0x90 port 1, 0xa0 port 2, 0xb0 port 3
// 0xc0 indirect pin setup for port 3
// Level registers read the synchronised pin levels,
// and a write sets the level that the pin drives.
// Reading a level register therefore shows the pad, not the latch;
// firmware that wants read-modify-write must keep a shadow copy.
// Setup register write layout:
//   [7:5] function mode to store
//   [4]   direction select, 0 output, 1 input
//   [3]   latch read pointer instead of storing a mode
//   [2:0] pin index, 0 to 6 valid, 7 reserved
// Setup register read layout:
//   [7:5] mode of the latched pin, input modes zero padded
//   [4]   latched direction
//   [2:0] latched pin index
// Bus timing:
//   every access costs exactly one wait cycle, so the master
//   sees waitrequest low on the second edge after it asserts
//   read or write, and the write lands on that same edge.
// Limitations:
//   only lane 0 matters, other lanes are ignored on write
//   and read back as zero;
//   illegal output codes are silently dropped, the previous
//   mode stays in force, and no error is flagged to software.
// Package handling:
//   port 3 setup and levels exist only on the largest package;
//   on the others every index counts as reserved and port 3
//   reads and drives zero.
// Reset:
//   all levels start high, all modes start at zero,
//   the read pointer starts at pin 0, output direction.

module gpcfg_port #(
    parameter [1:0] PACKAGE = 2'h2, // 2 largest, 1 medium, 0 smallest
    parameter [7:0] PORT0_MASK = 8'hff, // Pins present per port
    parameter [7:0] PORT1_MASK = 8'hff,
    parameter [7:0] PORT2_MASK = 8'hff,
    parameter [7:0] PORT3_MASK = 8'h7f
) (
    input wire clk,
    input wire rst_n,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    input wire [7:0] port0_pin_in,
    input wire [7:0] port1_pin_in,
    input wire [7:0] port2_pin_in,
    input wire [7:0] port3_pin_in,
    output reg [7:0] port0_pin_out,
    output reg [7:0] port1_pin_out,
    output reg [7:0] port2_pin_out,
    output reg [7:0] port3_pin_out,
    output reg [20:0] port3_out_mode,
    output reg [13:0] port3_in_mode
);

    // Pin sync stages; first stage is read only by the second
    reg [31:0] pin_s1_q;
    // Second stage, the only one logic may read
    reg [31:0] pin_s2_q;
    // Port level registers, one byte per port
    reg [7:0] lvl_q [0:3];
    // Stored output modes per pin
    reg [2:0] out_mode_q [0:6];
    // Stored input modes per pin, kept apart from output modes
    reg [1:0] in_mode_q [0:6];
    // Latched read pointer
    reg [2:0] rd_idx_q;
    // Latched direction for reads
    reg rd_dir_q;
    // Access phase: one wait cycle, then ack
    reg ack_q;

    // Lane 0 of the write data
    wire [7:0] wbyte;
    // Pin index field of a setup write
    wire [2:0] w_idx;
    // Direction field of a setup write
    wire w_dir;
    // Pointer latch field of a setup write
    wire w_latch;
    // Mode field of a setup write
    wire [2:0] w_mode;
    // High when port 3 exists on this package
    wire p3_present;
    // Write index names a real pin
    wire w_idx_ok;
    // Latched index names a real pin
    wire rd_idx_ok;
    // Write commits this edge
    wire do_wr;
    // Present pins per port
    wire [7:0] pin_mask [0:3];
    // Loop index, synthesis unrolls it
    integer i;

    assign wbyte = writedata[7:0];
    assign w_idx = wbyte[`GPCFG_IDX_HI:`GPCFG_IDX_LO];
    assign w_dir = wbyte[`GPCFG_DIR_BIT];
    assign w_latch = wbyte[`GPCFG_LATCH_BIT];
    assign w_mode = wbyte[`GPCFG_MODE_HI:`GPCFG_MODE_LO];
    // Port 3 config exists only on the largest package
    assign p3_present = (PACKAGE == `GPCFG_PKG_LARGE);
    assign w_idx_ok = p3_present && (w_idx != 3'h7);
    assign rd_idx_ok = p3_present && (rd_idx_q != 3'h7);
    // Write commits on the ack cycle, when waitrequest is low
    assign do_wr = write && ack_q && byteenable[0];
    // Masks of present pins; absent port 3 is all zero
    assign pin_mask[0] = PORT0_MASK;
    assign pin_mask[1] = PORT1_MASK;
    assign pin_mask[2] = PORT2_MASK;
    assign pin_mask[3] = p3_present ? PORT3_MASK : 8'h00;

    // Two flop synchroniser for pin levels
    // Pins are asynchronous; a bare read could go metastable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= 32'h0;
            pin_s2_q <= 32'h0;
        end else begin
            pin_s1_q <= {port3_pin_in, port2_pin_in, port1_pin_in, port0_pin_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Handshake: every access waits one cycle, then completes
    // Waitrequest is its own flop so the bus sees a clean output
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            waitrequest <= 1'b1;
        end else begin
            // Ack cycle follows the first cycle of a request
            ack_q <= (read || write) && !ack_q;
            // Low exactly while ack_q is high
            waitrequest <= !((read || write) && !ack_q);
        end
    end

    // Port level registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                lvl_q[i] <= `GPCFG_LEVELS_RST;
            end
        end else if (do_wr) begin
            case (address)
                `GPCFG_ADDR_PORT0: lvl_q[0] <= wbyte;
                `GPCFG_ADDR_PORT1: lvl_q[1] <= wbyte;
                `GPCFG_ADDR_PORT2: lvl_q[2] <= wbyte;
                `GPCFG_ADDR_PORT3: lvl_q[3] <= wbyte;
                default: begin
                    // Other addresses leave the levels alone
                end
            endcase
        end
    end

    // Indirect pin setup: latch pointer or update one pin config
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_idx_q <= 3'h0;
            rd_dir_q <= 1'b0;
            for (i = 0; i < 7; i = i + 1) begin
                out_mode_q[i] <= `GPCFG_MODE_RST;
                in_mode_q[i] <= 2'h0;
            end
        end else if (do_wr && address == `GPCFG_ADDR_SETUP) begin
            if (w_latch) begin
                // Mode field ignored on a pointer write
                // A reserved index may be latched; reads then give mode 0
                rd_idx_q <= w_idx;
                rd_dir_q <= w_dir;
            end else if (w_idx_ok) begin
                // Only the chosen direction of the chosen pin changes
                if (w_dir) begin
                    // Input modes use only two bits of the field
                    in_mode_q[w_idx] <= w_mode[1:0];
                end else if (w_mode == `GPCFG_OUT_NORMAL || w_mode == `GPCFG_OUT_HIGH) begin
                    // Illegal output codes are dropped so the pad never sees them
                    out_mode_q[w_idx] <= w_mode;
                end
            end
        end
    end

    // Read data, registered so it stands on the ack edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0;
        end else begin
            readdata <= 32'h0;
            if (read && !ack_q) begin
                case (address)
                    // Level reads show the synchronised pads
                    `GPCFG_ADDR_PORT0: readdata[7:0] <= pin_s2_q[7:0] & pin_mask[0];
                    `GPCFG_ADDR_PORT1: readdata[7:0] <= pin_s2_q[15:8] & pin_mask[1];
                    `GPCFG_ADDR_PORT2: readdata[7:0] <= pin_s2_q[23:16] & pin_mask[2];
                    `GPCFG_ADDR_PORT3: readdata[7:0] <= pin_s2_q[31:24] & pin_mask[3];
                    `GPCFG_ADDR_SETUP: begin
                        // Reserved pointer reads back zero mode
                        if (rd_idx_ok && rd_dir_q) begin
                            readdata[7:5] <= {1'b0, in_mode_q[rd_idx_q]};
                        end else if (rd_idx_ok) begin
                            readdata[7:5] <= out_mode_q[rd_idx_q];
                        end
                        readdata[4] <= rd_dir_q;
                        readdata[2:0] <= rd_idx_q;
                    end
                    default: readdata <= 32'h0;
                endcase
            end
        end
    end

    // Pin drive and mode outputs, absent pins held at zero
    // One extra flop stage keeps every top output straight from a flop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port0_pin_out <= `GPCFG_LEVELS_RST & PORT0_MASK;
            port1_pin_out <= `GPCFG_LEVELS_RST & PORT1_MASK;
            port2_pin_out <= `GPCFG_LEVELS_RST & PORT2_MASK;
            // Port 3 starts low until the mask applies on the first edge
            port3_pin_out <= 8'h00;
            port3_out_mode <= 21'h0;
            port3_in_mode <= 14'h0;
        end else begin
            port0_pin_out <= lvl_q[0] & pin_mask[0];
            port1_pin_out <= lvl_q[1] & pin_mask[1];
            port2_pin_out <= lvl_q[2] & pin_mask[2];
            port3_pin_out <= lvl_q[3] & pin_mask[3];
            // Flatten the per pin modes onto the pad control buses
            for (i = 0; i < 7; i = i + 1) begin
                port3_out_mode[3*i +: 3] <= out_mode_q[i];
                port3_in_mode[2*i +: 2] <= in_mode_q[i];
            end
        end
    end

endmodule // gpcfg_port

// file: tb/pcpv_checker.sv
`timescale 1ns/1ns
// Watches the register bus and the port 3 setup outputs
module pcpv_checker (
    input wire clk,
    input wire rst_n,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [7:0] port0_pin_out,
    input wire [7:0] port3_pin_out,
    input wire [20:0] port3_out_mode,
    input wire [13:0] port3_in_mode
);
    // Accepted lane 0 write and its setup fields
    wire wk = write && !waitrequest && byteenable[0];
    wire [2:0] ix = writedata[2:0];
    wire [2:0] md = writedata[7:5];
    // Mode update aimed at a present pin
    wire cw = wk && address == 8'hc0 && !writedata[3] && ix != 3'h7;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Modes and levels reach the outputs two edges after the write edge
    sequence s_wr(a);
        wk && address == a;
    endsequence
    property p_out;
        cw && !writedata[4] && (md == 3'h0 || md == 3'h3) |=> ##1 port3_out_mode[3*$past(ix, 2) +: 3] == $past(md, 2);
    endproperty
    a_out: assert property (p_out) else $error("output mode not loaded");
    property p_in;
        cw && writedata[4] |=> ##1 port3_in_mode[2*$past(ix, 2) +: 2] == $past(md[1:0], 2) && $stable(port3_out_mode);
    endproperty
    a_in: assert property (p_in) else $error("input mode not loaded");
    property p_ill;
        cw && !writedata[4] && md != 3'h0 && md != 3'h3 |=> ##1 $stable(port3_out_mode);
    endproperty
    a_ill: assert property (p_ill) else $error("illegal code accepted");
    property p_rsv;
        s_wr(8'hc0) and ix == 3'h7 |=> ##1 $stable(port3_out_mode) && $stable(port3_in_mode);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved index changed a mode");
    property p_lat;
        s_wr(8'hc0) and writedata[3] |=> ##1 $stable(port3_out_mode) && $stable(port3_in_mode);
    endproperty
    a_lat: assert property (p_lat) else $error("pointer write changed a mode");
    property p_lv0;
        s_wr(8'h80) |=> ##1 port0_pin_out == $past(writedata[7:0], 2);
    endproperty
    a_lv0: assert property (p_lv0) else $error("port 0 level not driven");
    property p_lv3;
        s_wr(8'hb0) |=> ##1 port3_pin_out == ($past(writedata[7:0], 2) & 8'h7f);
    endproperty
    a_lv3: assert property (p_lv3) else $error("port 3 level wrong");
    property p_rd;
        read && !waitrequest |-> readdata[31:8] == 24'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("upper read bits set");
endmodule // pcpv_checker
bind gpcfg_port pcpv_checker u_chk (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .port0_pin_out, .port3_pin_out, .port3_out_mode, .port3_in_mode);

// file: tb/tb_port3_pin_config_and_port_values.sv
`timescale 1ns/1ns
// Drives the register bus and pin levels, judges outputs
module tb_port3_pin_config_and_port_values;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] address = 8'h00;
    reg read = 1'b0;
    reg write = 1'b0;
    reg [31:0] writedata = 32'h0;
    reg [3:0] byteenable = 4'h1;
    reg [31:0] pins = 32'h78563412; // Port 3 bit 7 kept low, it is absent
    wire [31:0] readdata;
    wire waitrequest;
    wire [7:0] o0, o1, o2, o3;
    wire [20:0] om;
    wire [13:0] im;
    integer errors = 0;
    integer cmp_count = 0;
    integer i;
    reg [31:0] q;
    always #25 clk = ~clk;
    gpcfg_port u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .port0_pin_in(pins[7:0]), .port1_pin_in(pins[15:8]), .port2_pin_in(pins[23:16]),
        .port3_pin_in(pins[31:24]), .port0_pin_out(o0), .port1_pin_out(o1), .port2_pin_out(o2),
        .port3_pin_out(o3), .port3_out_mode(om), .port3_in_mode(im));
    // Verdict and end of run
    task test_done;
        begin
            if (errors == 0 && cmp_count > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [39:0] g, input [39:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("ERROR %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    // One bus cycle; request held until the rising edge that sees waitrequest low
    task bus(input rd, input [7:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge clk);
            read <= rd;
            write <= !rd;
            address <= a;
            writedata <= {24'h0, d};
            n = 0;
            @(posedge clk);
            while (waitrequest !== 1'b0 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 50) begin
                errors = errors + 1;
                test_done;
            end
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask
    task t_reset;
        begin
            repeat (2) @(posedge clk);
            chk({o0, o1, o2, o3}, 32'hffffff7f);
            chk({om, im}, 35'h0);
        end
    endtask
    task t_levels;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                bus(1'b1, {2'b10, i[1:0], 4'h0}, 8'h0);
                chk(q, pins[i*8 +: 8]);
                bus(1'b0, {2'b10, i[1:0], 4'h0}, {4'hc, i[3:0]});
            end
            repeat (2) @(posedge clk);
            chk({o0, o1, o2, o3}, 32'hc0c1c243);
        end
    endtask
    // Output mode 3, input mode 2 on pin 6, then rejected and pointer writes
    task t_modes;
        begin
            bus(1'b0, 8'hc0, 8'h66);
            bus(1'b0, 8'hc0, 8'h56);
            bus(1'b0, 8'hc0, 8'ha6);
            bus(1'b0, 8'hc0, 8'h67);
            bus(1'b0, 8'hc0, 8'hee);
            chk({om, im}, {21'hc0000, 14'h2000});
            bus(1'b1, 8'hc0, 8'h0);
            chk(q & 32'hf7, 32'h66);
            bus(1'b0, 8'hc0, 8'hfe);
            bus(1'b1, 8'hc0, 8'h0);
            chk(q & 32'hf7, 32'h56);
            bus(1'b1, 8'hd0, 8'h0);
            chk(q, 32'h0);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_levels;
        t_modes;
        test_done;
    end
endmodule // tb_port3_pin_config_and_port_values
